//--- common/ptprt_consts.vh
// register map, field positions, reset values and timing for the rate/trigger block
`ifndef PTPRT_CONSTS_VH
`define PTPRT_CONSTS_VH

// ==========================================================================
// register offsets (word index on the 16-bit register port)
`define PTPRT_OFF_CTRL        5'h14
`define PTPRT_OFF_TRIG_STATUS 5'h17
`define PTPRT_OFF_RATE_LOW    5'h18
`define PTPRT_OFF_RATE_HIGH   5'h19
`define PTPRT_OFF_TRIG_CTRL   5'h1c
`define PTPRT_OFF_DURATION    5'h1d
`define PTPRT_OFF_TIME_LO     5'h1e
`define PTPRT_OFF_TIME_HI     5'h1f
`define PTPRT_OFF_IRQ_STATUS  5'h10
`define PTPRT_OFF_IRQ_ENABLE  5'h11
`define PTPRT_OFF_IRQ_CLEAR   5'h12

// ==========================================================================
// rate high word fields
`define PTPRT_RH_DIR_BIT      15
`define PTPRT_RH_TMP_BIT      14
`define PTPRT_RH_MAG_MSB      9
`define PTPRT_RH_WR_MASK      16'hc3ff

// control register: bit 0 holds the time unit in reset
`define PTPRT_CTRL_RESET_BIT  0

// trigger control write: [2:0] trigger, [3] arm, [4] disable, [5] notify
`define PTPRT_TC_ARM_BIT      3
`define PTPRT_TC_DIS_BIT      4
`define PTPRT_TC_NOTIFY_BIT   5

// ==========================================================================
// reset values
`define PTPRT_RATE_HIGH_RST   16'h0000
`define PTPRT_RATE_MAG_RST    26'h0000000
`define PTPRT_ZERO16          16'h0000

// nominal reference period in ns, and fraction width of the time clock
`define PTPRT_REF_PERIOD_NS   20
`define PTPRT_FRAC_BITS       32

`endif

//--- design/ptprt_top.v
// precision clock rate adjust path and eight-trigger status view
//
// Operation
// R1: status word holds active at bit 2n, error at bit 2n+1
// R2: error set when armed target time is already past
// R3: error clears only on disable or re-arm of that trigger
// R4: active high while enabled and not yet completed
// R5: error sets only if that trigger's notify enable is set
// R6: rate magnitude counts 2^-32 ns per reference period
// R7: each cycle clock advances by nominal period plus or minus rate
// R8: software writes high rate word before low rate word
// R9: low word write loads full rate; high word alone changes nothing
// R10: direction bit 15: zero adds, one subtracts
// R11: bit 14 applies rate only for the temporary duration
// R12: bits 9:0 are top ten of twenty-six bit magnitude
// R13: high word bits 13:10 ignore writes, read zero
// R14: time unit reset bit holds clock and registers until cleared
// R15: after reset rate, direction, temporary mode are zero
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`include "ptprt_consts.vh"

module ptprt_top #(
    parameter NUM_TRIG = 8,
    parameter SEC_BITS = 32
) (
    // clock and reset
    input  wire        sys_clk_in,
    input  wire        nrst_in,
    // register port
    input  wire [4:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    // time clock and trigger status
    output reg  [63:0] time_ns_frac_out,
    output wire [15:0] trigger_status_out,
    output wire        irq_out
);

    // ======================================================================
    // register decode
    wire wr_ctrl = reg_wr_in && reg_addr_in == `PTPRT_OFF_CTRL;
    wire wr_rl   = reg_wr_in && reg_addr_in == `PTPRT_OFF_RATE_LOW;
    wire wr_rh   = reg_wr_in && reg_addr_in == `PTPRT_OFF_RATE_HIGH;
    wire wr_tc   = reg_wr_in && reg_addr_in == `PTPRT_OFF_TRIG_CTRL;
    wire wr_dur  = reg_wr_in && reg_addr_in == `PTPRT_OFF_DURATION;
    wire wr_ien  = reg_wr_in && reg_addr_in == `PTPRT_OFF_IRQ_ENABLE;
    wire wr_iclr = reg_wr_in && reg_addr_in == `PTPRT_OFF_IRQ_CLEAR;
    wire wr_tlo  = reg_wr_in && reg_addr_in == `PTPRT_OFF_TIME_LO;
    wire wr_thi  = reg_wr_in && reg_addr_in == `PTPRT_OFF_TIME_HI;

    // ======================================================================
    // time unit reset: survives its own reset so software can release it
    reg time_unit_reset;
    always @(posedge sys_clk_in) begin
        if (!nrst_in)
            time_unit_reset <= 1'b0;
        else if (wr_ctrl)
            time_unit_reset <= reg_wdata_in[`PTPRT_CTRL_RESET_BIT]; // see R14
    end
    wire unit_rst = !nrst_in || time_unit_reset; // see R14

    // ======================================================================
    // rate registers
    reg  [15:0] rate_high_word;
    reg  [25:0] rate_magnitude;
    reg         rate_direction;
    reg         temporary_rate_select;
    reg  [15:0] temporary_duration_reg;
    reg  [15:0] tmp_left;
    always @(posedge sys_clk_in) begin
        if (unit_rst) begin
            rate_high_word        <= `PTPRT_RATE_HIGH_RST; // see R15
            rate_magnitude        <= `PTPRT_RATE_MAG_RST;  // see R15
            rate_direction        <= 1'b0;
            temporary_rate_select <= 1'b0;
            temporary_duration_reg <= `PTPRT_ZERO16;
            tmp_left              <= `PTPRT_ZERO16;
        end else begin
            if (wr_rh) // reserved bits masked off; see R13
                rate_high_word <= reg_wdata_in & `PTPRT_RH_WR_MASK;
            if (wr_dur)
                temporary_duration_reg <= reg_wdata_in;
            if (wr_rl) begin
                // full value loads only here; see R9
                rate_magnitude <= {rate_high_word[`PTPRT_RH_MAG_MSB:0],
                                   reg_wdata_in}; // see R12
                rate_direction <= rate_high_word[`PTPRT_RH_DIR_BIT];
                temporary_rate_select <= rate_high_word[`PTPRT_RH_TMP_BIT];
                tmp_left <= temporary_duration_reg; // see R11
            end else if (temporary_rate_select && tmp_left != 16'h0000) begin
                tmp_left <= tmp_left - 16'h0001;
            end
        end
    end

    // temporary rate stops once its duration has run out
    wire rate_live = !temporary_rate_select || tmp_left != 16'h0000; // see R11
    wire [63:0] nominal = {32'h00000000 + `PTPRT_REF_PERIOD_NS, 32'h00000000};
    wire [63:0] adj = rate_live ? {38'h0, rate_magnitude} : 64'h0; // see R6

    // ======================================================================
    // time clock: integer ns in the top half, 2^-32 ns fraction below
    always @(posedge sys_clk_in) begin
        if (unit_rst)
            time_ns_frac_out <= 64'h0;
        else if (wr_tlo)
            time_ns_frac_out <= {time_ns_frac_out[63:48], reg_wdata_in, 32'h0};
        else if (wr_thi)
            time_ns_frac_out <= {reg_wdata_in, time_ns_frac_out[47:32], 32'h0};
        else if (rate_direction) // see R10
            time_ns_frac_out <= time_ns_frac_out + nominal - adj; // see R7
        else
            time_ns_frac_out <= time_ns_frac_out + nominal + adj; // see R7
    end
    wire [31:0] now_ns = time_ns_frac_out[63:32];

    // ======================================================================
    // triggers: target offset held in one shared word, added to now and latched per trigger on arm
    reg [15:0] trig_target_word;
    always @(posedge sys_clk_in) begin
        if (unit_rst)
            trig_target_word <= `PTPRT_ZERO16;
        else if (wr_dur)
            trig_target_word <= reg_wdata_in;
    end

    reg  [NUM_TRIG-1:0] trig_active;
    reg  [NUM_TRIG-1:0] trig_error;
    reg  [NUM_TRIG-1:0] trig_notify;
    reg  [31:0]         trig_target [0:NUM_TRIG-1];
    reg  [NUM_TRIG-1:0] done_evt;
    reg  [NUM_TRIG-1:0] err_evt;
    wire [2:0] tc_sel = reg_wdata_in[2:0];
    wire [31:0] arm_target = {16'h0000, trig_target_word} + now_ns;
    integer i;
    always @(posedge sys_clk_in) begin
        if (unit_rst) begin
            trig_active <= {NUM_TRIG{1'b0}};
            trig_error  <= {NUM_TRIG{1'b0}};
            trig_notify <= {NUM_TRIG{1'b0}};
            done_evt    <= {NUM_TRIG{1'b0}};
            err_evt     <= {NUM_TRIG{1'b0}};
            for (i = 0; i < NUM_TRIG; i = i + 1)
                trig_target[i] <= 32'h0;
        end else begin
            done_evt <= {NUM_TRIG{1'b0}};
            err_evt  <= {NUM_TRIG{1'b0}};
            for (i = 0; i < NUM_TRIG; i = i + 1) begin
                if (wr_tc && tc_sel == i[2:0] &&
                    reg_wdata_in[`PTPRT_TC_DIS_BIT]) begin
                    trig_active[i] <= 1'b0;
                    trig_error[i]  <= 1'b0; // see R3
                end else if (wr_tc && tc_sel == i[2:0] &&
                             reg_wdata_in[`PTPRT_TC_ARM_BIT]) begin
                    trig_notify[i] <= reg_wdata_in[`PTPRT_TC_NOTIFY_BIT];
                    trig_target[i] <= arm_target;
                    // offset with top bit set is a target in the past
                    if (trig_target_word[15]) begin
                        trig_active[i] <= 1'b0;
                        // see R2, R5
                        trig_error[i]  <=
                            reg_wdata_in[`PTPRT_TC_NOTIFY_BIT];
                        err_evt[i] <= reg_wdata_in[`PTPRT_TC_NOTIFY_BIT];
                    end else begin
                        trig_active[i] <= 1'b1; // see R4
                        trig_error[i]  <= 1'b0; // see R3
                    end
                end else if (trig_active[i] &&
                             now_ns >= trig_target[i]) begin
                    trig_active[i] <= 1'b0; // see R4
                    done_evt[i]    <= 1'b1;
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_TRIG; g = g + 1) begin : g_stat
            assign trigger_status_out[2*g]   = trig_active[g]; // see R1
            assign trigger_status_out[2*g+1] = trig_error[g];  // see R1
        end
    endgenerate

    // ======================================================================
    // interrupts: bit 0 trigger done, bit 1 trigger error; set wins clear
    reg [1:0] irq_status;
    reg [1:0] irq_enable;
    wire [1:0] irq_set = {|err_evt, |done_evt};
    always @(posedge sys_clk_in) begin
        if (unit_rst) begin
            irq_status <= 2'b00;
            irq_enable <= 2'b00;
        end else begin
            if (wr_ien)
                irq_enable <= reg_wdata_in[1:0];
            irq_status <= (irq_status & ~(wr_iclr ? reg_wdata_in[1:0]
                                                  : 2'b00)) | irq_set;
        end
    end
    assign irq_out = |(irq_status & irq_enable);

    // ======================================================================
    // read data, one cycle after the strobe; unmapped reads zero
    always @(posedge sys_clk_in) begin
        if (!nrst_in)
            reg_rdata_out <= `PTPRT_ZERO16;
        else if (reg_rd_in) begin
            case (reg_addr_in)
                `PTPRT_OFF_CTRL:
                    reg_rdata_out <= {15'h0000, time_unit_reset};
                `PTPRT_OFF_TRIG_STATUS: reg_rdata_out <= trigger_status_out;
                `PTPRT_OFF_RATE_HIGH:   reg_rdata_out <= rate_high_word;
                `PTPRT_OFF_DURATION: reg_rdata_out <= temporary_duration_reg;
                `PTPRT_OFF_TIME_LO: reg_rdata_out <= time_ns_frac_out[47:32];
                `PTPRT_OFF_TIME_HI: reg_rdata_out <= time_ns_frac_out[63:48];
                `PTPRT_OFF_IRQ_STATUS:
                    reg_rdata_out <= {14'h0000, irq_status};
                `PTPRT_OFF_IRQ_ENABLE:
                    reg_rdata_out <= {14'h0000, irq_enable};
                default: reg_rdata_out <= `PTPRT_ZERO16;
            endcase
        end else
            reg_rdata_out <= `PTPRT_ZERO16;
    end

endmodule // ptprt_top

//--- dv/ptprt_asserts.sv
// port checker for the rate/trigger block
`timescale 1ns/1ns
module ptprt_asserts (
    // clock, reset and register port
    input wire        sys_clk_in,
    input wire        nrst_in,
    input wire [4:0]  reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    // watched outputs
    input wire [15:0] reg_rdata_out,
    input wire [63:0] time_ns_frac_out,
    input wire [15:0] trigger_status_out,
    input wire        irq_out
);
    // ======================================================================
    // helper: a time, control or rate write ends the plain nominal stretch
    reg tuned;
    always @(posedge sys_clk_in) begin
        if (!nrst_in)
            tuned <= 1'b0;
        else if (reg_wr_in && (reg_addr_in == 5'h14 ||
                 reg_addr_in == 5'h18 || reg_addr_in >= 5'h1e))
            tuned <= 1'b1;
    end
    // ======================================================================
    // properties
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    chk_nominal_step: assert property (!tuned && !reg_wr_in && $past(nrst_in)
        |-> time_ns_frac_out == $past(time_ns_frac_out) + 64'h14_0000_0000)
        else $error("time step not nominal");
    chk_rh_reserved: assert property ($past(reg_rd_in && reg_addr_in == 5'h19)
        |-> reg_rdata_out[13:10] == 4'h0) else $error("reserved bits set");
    chk_status_read: assert property ($past(reg_rd_in && reg_addr_in == 5'h17)
        |-> reg_rdata_out == $past(trigger_status_out))
        else $error("status read differs");
    chk_err_rise: assert property (|(trigger_status_out & 16'haaaa &
        ~$past(trigger_status_out)) |-> $past(reg_wr_in && reg_addr_in == 5'h1c))
        else $error("error flag rose alone");
    // a control write takes the unit into reset one edge later, so the
    // flags it clears drop one edge after that write was taken and are seen two samples on
    chk_err_fall: assert property (|(~trigger_status_out & 16'haaaa &
        $past(trigger_status_out)) |-> $past(reg_wr_in &&
        reg_addr_in == 5'h1c) || $past(reg_wr_in && reg_addr_in == 5'h14, 2))
        else $error("error flag fell alone");
    chk_active_rise: assert property (|(trigger_status_out & 16'h5555 &
        ~$past(trigger_status_out)) |-> $past(reg_wr_in && reg_addr_in == 5'h1c))
        else $error("active flag rose alone");
    chk_reset_clear: assert property (!$past(nrst_in) |->
        time_ns_frac_out == 64'h0 && trigger_status_out == 16'h0000
        && !irq_out) else $error("reset not clean");
endmodule // ptprt_asserts

bind ptprt_top ptprt_asserts u_chk (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .irq_out(irq_out),
    .reg_rdata_out(reg_rdata_out), .time_ns_frac_out(time_ns_frac_out),
    .trigger_status_out(trigger_status_out));

//--- dv/rate_magnitude_and_trigger_status_test.sv
// self-checking bench for the rate/trigger block
`timescale 1ns/1ns
module rate_magnitude_and_trigger_status_test;
    reg         sys_clk_in = 1'b0;
    reg         nrst_in = 1'b0;
    reg  [4:0]  reg_addr_in = 5'h00;
    reg  [15:0] reg_wdata_in = 16'h0000;
    reg         reg_wr_in = 1'b0;
    reg         reg_rd_in = 1'b0;
    wire [15:0] reg_rdata_out;
    wire [63:0] time_ns_frac_out;
    wire [15:0] trigger_status_out;
    wire        irq_out;
    integer     miscompares = 0;
    integer     checks = 0;
    integer     i;
    reg  [63:0] t0;
    reg  [63:0] last;
    reg  [31:0] rows [0:3];
    localparam [63:0] NOM = 64'h14_0000_0000;

    ptprt_top DUT (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .time_ns_frac_out(time_ns_frac_out),
        .trigger_status_out(trigger_status_out), .irq_out(irq_out));

    initial begin
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    // ======================================================================
    // helpers
    task test_done;
        begin
            if (miscompares == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task cmp(input [63:0] got, input [63:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: %h not %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(posedge sys_clk_in);
            reg_wr_in <= 1'b1;
            reg_addr_in <= a;
            reg_wdata_in <= d;
            @(posedge sys_clk_in);
            reg_wr_in <= 1'b0;
        end
    endtask
    task rd(input [4:0] a, input [15:0] exp);
        begin
            @(posedge sys_clk_in);
            reg_rd_in <= 1'b1;
            reg_addr_in <= a;
            @(posedge sys_clk_in);
            reg_rd_in <= 1'b0;
            #1 cmp(reg_rdata_out, exp);
        end
    endtask
    // one full cycle of time advance, measured between settled samples
    task step(input [63:0] exp);
        begin
            @(posedge sys_clk_in) #1 t0 = time_ns_frac_out;
            @(posedge sys_clk_in) #1 cmp(time_ns_frac_out - t0, exp);
        end
    endtask
    function [63:0] rate(input [31:0] hl);
        rate = hl[31] ? NOM - hl[25:0] : NOM + hl[25:0];
    endfunction
    // ======================================================================
    // sequence
    initial begin
        rows[0] = 32'h0000_0001;
        rows[1] = 32'h8000_0010;
        rows[2] = 32'h3c01_0000;
        rows[3] = 32'h83ff_ffff;
        repeat (5) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        rd(5'h19, 16'h0000);
        step(NOM);
        last = NOM;
        for (i = 0; i < 4; i = i + 1) begin
            wr(5'h19, rows[i][31:16]);
            step(last);
            rd(5'h19, rows[i][31:16] & 16'hc3ff);
            wr(5'h18, rows[i][15:0]);
            last = rate(rows[i]);
            step(last);
        end
        wr(5'h1d, 16'h0005);
        wr(5'h19, 16'h4000);
        wr(5'h18, 16'h0100);
        step(NOM + 64'h100);
        repeat (6) @(posedge sys_clk_in);
        step(NOM);
        wr(5'h1d, 16'h8000);
        wr(5'h1c, 16'h0008);
        rd(5'h17, 16'h0000);
        wr(5'h1c, 16'h002f);
        rd(5'h17, 16'h8000);
        wr(5'h1c, 16'h0017);
        rd(5'h17, 16'h0000);
        wr(5'h1c, 16'h002f);
        wr(5'h1d, 16'h0100);
        wr(5'h1c, 16'h002f);
        wr(5'h1c, 16'h002a);
        rd(5'h17, 16'h4010);
        repeat (20) @(posedge sys_clk_in);
        rd(5'h17, 16'h0000);
        @(posedge sys_clk_in) #1 cmp(irq_out, 1'b0);
        wr(5'h11, 16'h0003);
        @(posedge sys_clk_in) #1 cmp(irq_out, 1'b1);
        wr(5'h12, 16'h0003);
        @(posedge sys_clk_in) #1 cmp(irq_out, 1'b0);
        rd(5'h00, 16'h0000);
        wr(5'h14, 16'h0001);
        step(64'h0);
        rd(5'h19, 16'h0000);
        wr(5'h14, 16'h0000);
        step(NOM);
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        repeat (5) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        step(NOM);
        test_done;
    end

    // the run needs about 140 cycles; this leaves ample margin
    initial begin
        #40000;
        miscompares = miscompares + 1;
        test_done;
    end
endmodule // rate_magnitude_and_trigger_status_test
